/* shared/rcrc_pkg.sv */
`default_nettype none
package rcrc_pkg;
	// ---------------------------------------------------------------
	// Register geometry
	// ---------------------------------------------------------------
	localparam int REG_W = 16;
	localparam int IDX_W = 6;
	localparam int PADDR_W = 8;
	localparam int PDATA_W = 32;
	localparam int ADDR_LSB = 2;
	localparam logic [IDX_W-1:0] IDX_STATUS = 6'h01;
	localparam logic [IDX_W-1:0] IDX_MODE = 6'h02;
	localparam logic [IDX_W-1:0] IDX_CH2 = 6'h03;
	localparam logic [IDX_W-1:0] IDX_GCHOP = 6'h04;
	localparam logic [IDX_W-1:0] IDX_MEM_FIRST = 6'h05;
	localparam logic [IDX_W-1:0] IDX_CHECK_FIRST = 6'h02;
	localparam logic [IDX_W-1:0] IDX_CHECK_LAST = 6'h31;
	localparam logic [IDX_W-1:0] IDX_RESULT = 6'h3e;
	localparam logic [IDX_W-1:0] IDX_MASK = 6'h3f;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int MODE_CHECK_EN_BIT = 0;
	localparam int MODE_CHECK_TYPE_BIT = 1;
	localparam int CH2_TEMP_EN_BIT = 0;
	localparam int CH2_TEMP_SRC_BIT = 1;
	localparam int CH2_GAIN_LSB = 2;
	localparam int GAIN_W = 3;
	localparam int GCHOP_EN_BIT = 0;
	localparam int STAT_W = 2;
	localparam int STAT_MAP_CHANGED_BIT = 0;
	localparam int STAT_CHAN2_AVAIL_BIT = 1;

	// ---------------------------------------------------------------
	// Reset values and checksum constants
	// ---------------------------------------------------------------
	localparam logic [REG_W-1:0] MODE_RESET = 16'h0000;
	localparam logic [REG_W-1:0] CH2_RESET = 16'h0000;
	localparam logic [REG_W-1:0] GCHOP_RESET = 16'h0000;
	localparam logic [REG_W-1:0] RESULT_RESET = 16'h0000;
	localparam logic [STAT_W-1:0] MASK_RESET = 2'h0;
	localparam logic [REG_W-1:0] CHECK_SEED = 16'hffff;
	localparam logic [REG_W-1:0] POLY_CCITT = 16'h1021;
	localparam logic [REG_W-1:0] POLY_ANSI = 16'h8005;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int TEMP_RATE_DIV = 32;
	localparam int TEMP_CNT_W = 5;
	localparam int DATA_READY_N_LOW_TIME_NS = 40;
	localparam int DATA_READY_N_LOW_CYCLES = (DATA_READY_N_LOW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DATA_READY_N_CNT_W = 3;

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {CH2_SRC_PINS, CH2_SRC_DIODE, CH2_SRC_EXT} rcrc_ch2_src_type;
	typedef enum logic [1:0] {SCAN_IDLE, SCAN_FETCH, SCAN_LOAD, SCAN_SHIFT} rcrc_scan_type;

	typedef struct packed {
		logic wrEn;
		logic [IDX_W-1:0] wrAddr;
		logic [REG_W-1:0] wrData;
		logic [IDX_W-1:0] rdAddr;
	} rcrc_mem_req_type;

	typedef struct packed {
		rcrc_scan_type scan;
		logic [IDX_W-1:0] scanIdx;
		logic [3:0] bitCnt;
		logic [REG_W-1:0] crc;
		logic [REG_W-1:0] shifter;
		logic [REG_W-1:0] result;
		logic [REG_W-1:0] modeReg;
		logic [REG_W-1:0] ch2Reg;
		logic [REG_W-1:0] gchopReg;
		logic [STAT_W-1:0] maskReg;
		logic [STAT_W-1:0] status;
		logic pready;
		logic pslverr;
		logic [PDATA_W-1:0] prdata;
		logic irq;
		logic drdyN;
		logic [DATA_READY_N_CNT_W-1:0] drdyCnt;
		logic [TEMP_CNT_W-1:0] convCnt;
		logic [TEMP_CNT_W-1:0] modCnt;
		logic chan2Strobe;
		logic chan01ModStrobe;
		logic chan2ModStrobe;
		rcrc_ch2_src_type ch2Src;
		logic [GAIN_W-1:0] ch2Gain;
		logic refRatio;
		logic gcOut;
	} rcrc_state_type;
endpackage
`default_nettype wire

/* hw/rcrc_cfg_mem.sv */
`timescale 1ns/10ps
`default_nettype none
module rcrc_cfg_mem
	import rcrc_pkg::*;
#(
	parameter int WIDTH = 16,
	parameter int ADDR_W = 6
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wrEn,
	input wire logic [ADDR_W-1:0] wrAddr,
	input wire logic [WIDTH-1:0] wrData,
	input wire logic [ADDR_W-1:0] rdAddr,
	output logic [WIDTH-1:0] rdData
);
	// ---------------------------------------------------------------
	// Storage with registered read
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [(1<<ADDR_W)-1:0][WIDTH-1:0] words;
		logic [WIDTH-1:0] rd;
	} rcrc_mem_state_type;

	rcrc_mem_state_type st;
	rcrc_mem_state_type next_st;

	always_comb
	begin
		next_st = st;
		next_st.rd = st.words[rdAddr];
		if (wrEn)
		begin
			next_st.words[wrAddr] = wrData;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st <= '0;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign rdData = st.rd;
endmodule
`default_nettype wire

/* hw/rcrc_top.sv */
`timescale 1ns/10ps
`default_nettype none
module rcrc_top
	import rcrc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [PADDR_W-1:0] paddr,
	input wire logic [PDATA_W-1:0] pwdata,
	output logic [PDATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic convTick,
	input wire logic modTick,
	input wire logic nullStatusReply,
	output logic irq,
	output logic dataReadyN,
	output logic chan2ResultStrobe,
	output logic chan01ModStrobe,
	output logic chan2ModStrobe,
	output rcrc_ch2_src_type chan2InputSelect,
	output logic [GAIN_W-1:0] chan2Gain,
	output logic chan2RefRatiometric,
	output logic globalChopEnable
);
	// ---------------------------------------------------------------
	// Checksum step
	// ---------------------------------------------------------------
	function automatic logic [REG_W-1:0] checkStep(
		input logic [REG_W-1:0] crc,
		input logic bitIn,
		input logic useAnsi
	);
		logic feedback;
		feedback = crc[REG_W-1] ^ bitIn;
		checkStep = {crc[REG_W-2:0], 1'b0};
		if (feedback)
		begin
			checkStep = checkStep ^ (useAnsi ? POLY_ANSI : POLY_CCITT);
		end
	endfunction

	rcrc_state_type st;
	rcrc_state_type next_st;
	rcrc_mem_req_type memReq;
	logic [REG_W-1:0] memRdData;

	// ---------------------------------------------------------------
	// Bus decode
	// ---------------------------------------------------------------
	logic [IDX_W-1:0] busIdx;
	logic isMem;
	logic mapped;
	logic apbSetup;
	logic apbAccess;
	logic apbDone;
	logic apbMemRead;
	logic checkEnable;
	logic checkAnsi;
	logic tempMode;
	logic tempExt;
	logic [REG_W-1:0] stepped;

	assign busIdx = paddr[ADDR_LSB +: IDX_W];
	assign isMem = (busIdx >= IDX_MEM_FIRST) && (busIdx <= IDX_CHECK_LAST);
	assign mapped = isMem || (busIdx == IDX_STATUS) || (busIdx == IDX_MODE)
		|| (busIdx == IDX_CH2) || (busIdx == IDX_GCHOP) || (busIdx == IDX_RESULT)
		|| (busIdx == IDX_MASK);
	assign apbSetup = psel && !penable;
	assign apbAccess = psel && penable && !st.pready;
	assign apbDone = psel && penable && st.pready;
	assign apbMemRead = apbSetup && isMem && !pwrite;
	assign checkEnable = st.modeReg[MODE_CHECK_EN_BIT];
	assign checkAnsi = st.modeReg[MODE_CHECK_TYPE_BIT];
	assign tempMode = st.ch2Reg[CH2_TEMP_EN_BIT];
	assign tempExt = st.ch2Reg[CH2_TEMP_SRC_BIT];
	assign stepped = checkStep(st.crc, st.shifter[REG_W-1], checkAnsi);

	// ---------------------------------------------------------------
	// Memory port sharing
	// ---------------------------------------------------------------
	always_comb
	begin
		memReq.wrEn = apbDone && pwrite && isMem;
		memReq.wrAddr = busIdx;
		memReq.wrData = pwdata[REG_W-1:0];
		memReq.rdAddr = apbMemRead ? busIdx : st.scanIdx;
	end

	rcrc_cfg_mem #(
		.WIDTH(REG_W),
		.ADDR_W(IDX_W)
	) rcrc_cfg_mem_inst (
		.clk(clk),
		.rst_n(rst_n),
		.wrEn(memReq.wrEn),
		.wrAddr(memReq.wrAddr),
		.wrData(memReq.wrData),
		.rdAddr(memReq.rdAddr),
		.rdData(memRdData)
	);

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	logic [STAT_W-1:0] statSet;
	logic [STAT_W-1:0] statClr;
	logic passDone;
	logic chan2Due;
	logic modDue;

	always_comb
	begin
		next_st = st;
		statSet = '0;
		statClr = '0;
		passDone = 1'b0;
		chan2Due = 1'b0;
		modDue = 1'b0;

		// Bus slave
		next_st.pready = apbAccess;
		if (apbAccess)
		begin
			next_st.pslverr = !mapped;
			next_st.prdata = '0;
			if (!pwrite)
			begin
				case (busIdx)
					IDX_STATUS: next_st.prdata[STAT_W-1:0] = st.status;
					IDX_MODE: next_st.prdata[REG_W-1:0] = st.modeReg;
					IDX_CH2: next_st.prdata[REG_W-1:0] = st.ch2Reg;
					IDX_GCHOP: next_st.prdata[REG_W-1:0] = st.gchopReg;
					IDX_RESULT: next_st.prdata[REG_W-1:0] = st.result;
					IDX_MASK: next_st.prdata[STAT_W-1:0] = st.maskReg;
					default: next_st.prdata[REG_W-1:0] = isMem ? memRdData : '0;
				endcase
			end
		end
		if (apbDone && pwrite)
		begin
			case (busIdx)
				IDX_MODE: next_st.modeReg = pwdata[REG_W-1:0];
				IDX_CH2: next_st.ch2Reg = pwdata[REG_W-1:0];
				IDX_GCHOP: next_st.gchopReg = pwdata[REG_W-1:0];
				IDX_MASK: next_st.maskReg = pwdata[STAT_W-1:0];
				default: next_st.modeReg = st.modeReg;
			endcase
		end
		if (apbDone && !pwrite && (busIdx == IDX_STATUS))
		begin
			statClr = st.prdata[STAT_W-1:0];
		end
		if (nullStatusReply)
		begin
			statClr = '1;
		end

		// Checksum scan
		case (st.scan)
			SCAN_IDLE:
			begin
				if (checkEnable)
				begin
					next_st.crc = CHECK_SEED;
					next_st.scanIdx = IDX_CHECK_FIRST;
					next_st.scan = SCAN_FETCH;
				end
			end
			SCAN_FETCH:
			begin
				if (!apbMemRead)
				begin
					next_st.scan = SCAN_LOAD;
				end
			end
			SCAN_LOAD:
			begin
				case (st.scanIdx)
					IDX_MODE: next_st.shifter = st.modeReg;
					IDX_CH2: next_st.shifter = st.ch2Reg;
					IDX_GCHOP: next_st.shifter = st.gchopReg;
					default: next_st.shifter = memRdData;
				endcase
				next_st.bitCnt = '0;
				next_st.scan = SCAN_SHIFT;
			end
			SCAN_SHIFT:
			begin
				next_st.crc = stepped;
				next_st.shifter = {st.shifter[REG_W-2:0], 1'b0};
				next_st.bitCnt = st.bitCnt + 4'h1;
				if (st.bitCnt == 4'hf)
				begin
					if (st.scanIdx == IDX_CHECK_LAST)
					begin
						passDone = 1'b1;
						next_st.scan = SCAN_IDLE;
					end
					else
					begin
						next_st.scanIdx = st.scanIdx + 6'h01;
						next_st.scan = SCAN_FETCH;
					end
				end
			end
			default: next_st.scan = SCAN_IDLE;
		endcase
		if (!checkEnable)
		begin
			next_st.scan = SCAN_IDLE;
		end
		if (passDone)
		begin
			next_st.result = stepped;
			if (stepped != st.result)
			begin
				statSet[STAT_MAP_CHANGED_BIT] = 1'b1;
			end
		end

		// Conversion pacing
		next_st.chan2Strobe = 1'b0;
		if (convTick)
		begin
			next_st.drdyN = 1'b0;
			next_st.drdyCnt = DATA_READY_N_CNT_W'(DATA_READY_N_LOW_CYCLES - 1);
			if (tempMode)
			begin
				chan2Due = (st.convCnt == TEMP_CNT_W'(TEMP_RATE_DIV - 1));
				next_st.convCnt = st.convCnt + 5'h01;
			end
			else
			begin
				chan2Due = 1'b1;
				next_st.convCnt = '0;
			end
		end
		else if (!st.drdyN)
		begin
			if (st.drdyCnt == '0)
			begin
				next_st.drdyN = 1'b1;
			end
			else
			begin
				next_st.drdyCnt = st.drdyCnt - 3'h1;
			end
		end
		if (!tempMode)
		begin
			next_st.convCnt = '0;
		end
		if (chan2Due)
		begin
			next_st.chan2Strobe = 1'b1;
			statSet[STAT_CHAN2_AVAIL_BIT] = 1'b1;
		end

		// Modulator strobes
		next_st.chan01ModStrobe = modTick;
		if (modTick)
		begin
			modDue = tempMode ? (st.modCnt == TEMP_CNT_W'(TEMP_RATE_DIV - 1)) : 1'b1;
			next_st.modCnt = tempMode ? st.modCnt + 5'h01 : '0;
		end
		if (!tempMode)
		begin
			next_st.modCnt = '0;
		end
		next_st.chan2ModStrobe = modDue;

		// Channel 2 front-end steering
		if (!tempMode)
		begin
			next_st.ch2Src = CH2_SRC_PINS;
		end
		else if (tempExt)
		begin
			next_st.ch2Src = CH2_SRC_EXT;
		end
		else
		begin
			next_st.ch2Src = CH2_SRC_DIODE;
		end
		next_st.refRatio = tempMode && tempExt;
		next_st.ch2Gain = st.ch2Reg[CH2_GAIN_LSB +: GAIN_W];
		next_st.gcOut = st.gchopReg[GCHOP_EN_BIT];

		// Sticky status, set wins over clear
		next_st.status = (st.status & ~statClr) | statSet;
		next_st.irq = |(next_st.status & st.maskReg);
	end

	// ---------------------------------------------------------------
	// State register
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st <= '0;
			st.scan <= SCAN_IDLE;
			st.modeReg <= MODE_RESET;
			st.ch2Reg <= CH2_RESET;
			st.gchopReg <= GCHOP_RESET;
			st.maskReg <= MASK_RESET;
			st.result <= RESULT_RESET;
			st.crc <= CHECK_SEED;
			st.drdyN <= 1'b1;
			st.ch2Src <= CH2_SRC_PINS;
		end
		else
		begin
			st <= next_st;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign irq = st.irq;
	assign dataReadyN = st.drdyN;
	assign chan2ResultStrobe = st.chan2Strobe;
	assign chan01ModStrobe = st.chan01ModStrobe;
	assign chan2ModStrobe = st.chan2ModStrobe;
	assign chan2InputSelect = st.ch2Src;
	assign chan2Gain = st.ch2Gain;
	assign chan2RefRatiometric = st.refRatio;
	assign globalChopEnable = st.gcOut;
endmodule
`default_nettype wire

/* testbench/rcrc_top_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module rcrc_checker
	import rcrc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic convTick,
	input wire logic modTick,
	input wire logic dataReadyN,
	input wire logic chan2ResultStrobe,
	input wire logic chan01ModStrobe,
	input wire logic chan2ModStrobe,
	input wire rcrc_ch2_src_type chan2InputSelect,
	input wire logic chan2RefRatiometric
);
	// ----------------------------------------
	// Port relations
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	a_ready_fall: assert property (convTick |=> !dataReadyN)
		else $error("ready flag not low after tick");
	a_ready_width: assert property (convTick ##1 !convTick [*4] |=> dataReadyN)
		else $error("ready flag low too long");
	a_apb_answer: assert property (psel && !penable |-> ##2 pready)
		else $error("bus answer late");
	a_mod_both: assert property (modTick |=> chan01ModStrobe)
		else $error("channel 0 1 modulator strobe missing");
	a_mod_plain: assert property (modTick && chan2InputSelect == CH2_SRC_PINS
		##1 chan2InputSelect == CH2_SRC_PINS |-> chan2ModStrobe) else $error("mod strobe missing");
	a_mod_subset: assert property (chan2ModStrobe |-> chan01ModStrobe)
		else $error("channel 2 strobe off the grid");
	a_res_plain: assert property (convTick && chan2InputSelect == CH2_SRC_PINS
		##1 chan2InputSelect == CH2_SRC_PINS |-> chan2ResultStrobe) else $error("result missing");
	a_res_cause: assert property (chan2ResultStrobe |-> $past(convTick) && !dataReadyN)
		else $error("result strobe without tick");
	a_ref_ext: assert property (chan2RefRatiometric == (chan2InputSelect == CH2_SRC_EXT))
		else $error("reference choice wrong");
endmodule
bind rcrc_top rcrc_checker rcrc_checker_inst (.*);
`default_nettype wire

/* testbench/rcrc_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module rcrc_host_model
	import rcrc_pkg::*;
(
	input wire logic clk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [PADDR_W-1:0] paddr,
	output logic [PDATA_W-1:0] pwdata,
	input wire logic [PDATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	// ----------------------------------------
	// Bus cycles
	// ----------------------------------------
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	task automatic xfer(input logic w, input logic [IDX_W-1:0] idx, input logic [PDATA_W-1:0] wd,
		output logic [PDATA_W-1:0] rd, output logic err);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
		begin
			@(posedge clk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic setTemp(input logic ext);
		logic [PDATA_W-1:0] r;
		logic e;
		xfer(1'b1, IDX_GCHOP, 32'h0, r, e);
		xfer(1'b1, IDX_CH2, {27'h0, ext ? 3'h0 : 3'h3, ext, 1'b1}, r, e);
	endtask
endmodule
`default_nettype wire

/* testbench/regmap_check_result_and_temp_channel_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module regmap_check_result_and_temp_channel_tb
	import rcrc_pkg::*;
;
	typedef struct {logic [IDX_W-1:0] idx; logic [31:0] wd; logic [31:0] rd; logic err;} rcrc_row_type;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr, convTick, modTick, irq, err;
	logic nullStatusReply, dataReadyN, chan2ResultStrobe, chan01ModStrobe, chan2ModStrobe;
	logic chan2RefRatiometric, globalChopEnable;
	logic [PADDR_W-1:0] paddr;
	logic [PDATA_W-1:0] pwdata, prdata, rd;
	logic [GAIN_W-1:0] chan2Gain;
	rcrc_ch2_src_type chan2InputSelect;
	int nErrors, nTests, s2, m2, m01, b2, bm2, bm01;
	logic [15:0] img [64];
	rcrc_row_type rows [6] = '{'{IDX_MEM_FIRST, 32'hffff_a5a5, 32'h0000_a5a5, 1'b0},
		'{6'h31, 32'h0000_1234, 32'h0000_1234, 1'b0}, '{IDX_GCHOP, 32'h1, 32'h1, 1'b0},
		'{IDX_RESULT, 32'h0000_ffff, 32'h0, 1'b0}, '{6'h3d, 32'h5555, 32'h0, 1'b1},
		'{IDX_MASK, 32'h3, 32'h3, 1'b0}};
	rcrc_top rcrc_top_inst (
		.clk(clk),
		.rst_n(rst_n),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.convTick(convTick),
		.modTick(modTick),
		.nullStatusReply(nullStatusReply),
		.irq(irq),
		.dataReadyN(dataReadyN),
		.chan2ResultStrobe(chan2ResultStrobe),
		.chan01ModStrobe(chan01ModStrobe),
		.chan2ModStrobe(chan2ModStrobe),
		.chan2InputSelect(chan2InputSelect),
		.chan2Gain(chan2Gain),
		.chan2RefRatiometric(chan2RefRatiometric),
		.globalChopEnable(globalChopEnable)
	);
	rcrc_host_model rcrc_host_model_inst (
		.clk(clk),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr)
	);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	always #(CLK_PERIOD_NS / 2) clk = ~clk;
	always @(negedge clk)
	begin
		s2 <= s2 + int'(chan2ResultStrobe);
		m2 <= m2 + int'(chan2ModStrobe);
		m01 <= m01 + int'(chan01ModStrobe);
	end
	task chk(input logic [32:0] got, input logic [32:0] exp);
		nTests++;
		if (got !== exp)
		begin
			nErrors++;
			$display("wrong value at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task reportAndStop;
		if (nErrors == 0 && nTests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task wr(input logic [IDX_W-1:0] idx, input logic [31:0] v);
		rcrc_host_model_inst.xfer(1'b1, idx, v, rd, err);
		if (idx <= IDX_CHECK_LAST)
			img[idx] = v[15:0];
	endtask
	task rdr(input logic [IDX_W-1:0] idx);
		rcrc_host_model_inst.xfer(1'b0, idx, 32'h0, rd, err);
	endtask
	task tick(input int n);
		repeat (n)
		begin
			@(posedge clk);
			convTick <= 1'b1;
			modTick <= 1'b1;
			@(posedge clk);
			convTick <= 1'b0;
			modTick <= 1'b0;
			repeat (4) @(posedge clk);
		end
		repeat (2) @(negedge clk);
	endtask
	function automatic logic [15:0] crcOf(input logic [15:0] poly);
		logic [15:0] c;
		c = CHECK_SEED;
		for (int i = int'(IDX_CHECK_FIRST); i <= int'(IDX_CHECK_LAST); i++)
			for (int b = 15; b >= 0; b--)
				c = {c[14:0], 1'b0} ^ ((c[15] ^ img[i][b]) ? poly : 16'h0000);
		return c;
	endfunction
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial
	begin
		#(20000 * CLK_PERIOD_NS);
		nErrors++;
		reportAndStop();
	end
	initial
	begin
		clk = 1'b0;
		rst_n = 1'b0;
		convTick = 1'b0;
		modTick = 1'b0;
		nullStatusReply = 1'b0;
		foreach (img[i])
			img[i] = 16'h0000;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		chk({dataReadyN, irq, chan2InputSelect}, {1'b1, 1'b0, CH2_SRC_PINS});
		foreach (rows[i])
		begin
			wr(rows[i].idx, rows[i].wd);
			chk(err, rows[i].err);
			rdr(rows[i].idx);
			chk({err, rd}, {rows[i].err, rows[i].rd});
		end
		chk(globalChopEnable, 1'b1);
		wr(IDX_MODE, 32'h1);
		repeat (3000) @(posedge clk);
		chk(irq, 1'b1);
		rdr(IDX_RESULT);
		chk(rd, crcOf(POLY_CCITT));
		rdr(IDX_STATUS);
		chk(rd, 32'h1);
		rdr(IDX_STATUS);
		chk(rd, 32'h0);
		repeat (2000) @(posedge clk);
		rdr(IDX_STATUS);
		chk({irq, rd}, 33'h0);
		wr(IDX_MODE, 32'h3);
		repeat (3000) @(posedge clk);
		rdr(IDX_RESULT);
		chk({irq, rd}, {1'b1, 16'h0, crcOf(POLY_ANSI)});
		nullStatusReply <= 1'b1;
		@(posedge clk);
		nullStatusReply <= 1'b0;
		rdr(IDX_STATUS);
		chk(rd, 32'h0);
		wr(IDX_MODE, 32'h0);
		rcrc_host_model_inst.setTemp(1'b0);
		repeat (2) @(negedge clk);
		chk({chan2InputSelect, chan2Gain}, {CH2_SRC_DIODE, 3'h3});
		b2 = s2;
		bm2 = m2;
		bm01 = m01;
		tick(31);
		chk(s2 - b2 + m2 - bm2, 0);
		rdr(IDX_STATUS);
		chk(rd[1], 1'b0);
		tick(1);
		chk(s2 - b2, 1);
		chk(m2 - bm2, 1);
		chk(m01 - bm01, 32);
		rdr(IDX_STATUS);
		chk(rd[1], 1'b1);
		rcrc_host_model_inst.setTemp(1'b1);
		repeat (2) @(negedge clk);
		chk({chan2InputSelect, chan2RefRatiometric}, {CH2_SRC_EXT, 1'b1});
		wr(IDX_CH2, 32'h0);
		repeat (2) @(negedge clk);
		chk(chan2InputSelect, CH2_SRC_PINS);
		b2 = s2;
		tick(2);
		chk(s2 - b2, 2);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		chk({dataReadyN, irq, chan2InputSelect, chan2RefRatiometric}, 5'h10);
		rdr(IDX_RESULT);
		chk(rd, 32'h0);
		reportAndStop();
	end
endmodule
`default_nettype wire
